// >>> tdc_pkg.sv
`default_nettype none
package tdc_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [7:0] SPC_ADDR = 8'h1b;
  localparam logic [7:0] FHB_ADDR = 8'h1c;
  localparam logic [7:0] SHB_ADDR = 8'h1d;

  // signal_path_config fields
  localparam int SPC_PREMOD_BYP = 7;
  localparam int SPC_ISINC_BYP = 6;
  localparam int SPC_OSC_BYP = 5;
  localparam int SPC_OSC_HALF = 3;
  localparam int SPC_PHDC_BYP = 2;
  localparam int SPC_LOW_SIDE = 1;
  localparam int SPC_MIRROR_I = 0;

  // Halfband config fields
  localparam int HB_BYP = 0;
  localparam int HB_MODE_LSB = 1;
  localparam int FHB_MODE_W = 2;
  localparam int SHB_MODE_W = 6;
  localparam int FHB_CODE_W = 2;
  localparam int FHB_REPS = 1;
  localparam int SHB_CODE_W = 3;
  localparam int SHB_REPS = 2;
  localparam int BAND_W = 3;

  // Reset values
  localparam logic [7:0] SPC_RST = 8'he4;
  localparam logic [7:0] FHB_RST = 8'h00;
  localparam logic [7:0] SHB_RST = 8'h00;

  // Implemented bits; all others store nothing and read zero
  localparam logic [7:0] SPC_MASK = 8'hef;
  localparam logic [7:0] FHB_MASK = 8'h07;
  localparam logic [7:0] SHB_MASK = 8'h7f;

  typedef struct packed {
    logic premod_bypass;
    logic isinc_bypass;
    logic osc_bypass;
    logic osc_half_gain;
    logic phase_dc_bypass;
    logic low_sideband;
    logic mirror_inphase;
    logic q_clk_en;
  } tdc_path_cfg_s;

  typedef struct packed {
    logic bypass;
    logic modulate;
    logic [BAND_W-1:0] band;
    logic code_mismatch;
  } tdc_hb_cfg_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } tdc_bus_req_s;

endpackage : tdc_pkg
`default_nettype wire

// >>> tdc_hb_dec.sv
`default_nettype none
module tdc_hb_dec #(
  parameter int CODE_W = 3,
  parameter int REPS = 2,
  parameter int BAND_W = 3
) (
  input wire logic [CODE_W*REPS-1:0] mode,
  output logic modulate,
  output logic [BAND_W-1:0] band,
  output logic mismatch
);

  logic [REPS-1:0] diff;

  // Every copy of the pattern must match the top copy
  genvar g;
  generate
    for (g = 0; g < REPS; g++) begin : g_rep
      assign diff[g] = mode[g*CODE_W +: CODE_W] != mode[(REPS-1)*CODE_W +: CODE_W];
    end
  endgenerate

  // Top copy governs, so a malformed code still picks a defined band
  assign band = BAND_W'(mode[(REPS-1)*CODE_W +: CODE_W]);
  assign modulate = mode[CODE_W*REPS-1];
  assign mismatch = |diff;

endmodule : tdc_hb_dec
`default_nettype wire

// >>> tdc_path_dec.sv
`default_nettype none
module tdc_path_dec (
  input wire logic [7:0] spc,
  output tdc_pkg::tdc_path_cfg_s cfg
);

  always_comb begin
    cfg.premod_bypass = spc[tdc_pkg::SPC_PREMOD_BYP];
    cfg.isinc_bypass = spc[tdc_pkg::SPC_ISINC_BYP];
    cfg.osc_bypass = spc[tdc_pkg::SPC_OSC_BYP];
    cfg.osc_half_gain = spc[tdc_pkg::SPC_OSC_HALF];
    cfg.phase_dc_bypass = spc[tdc_pkg::SPC_PHDC_BYP];
    cfg.low_sideband = spc[tdc_pkg::SPC_LOW_SIDE];
    cfg.mirror_inphase = spc[tdc_pkg::SPC_MIRROR_I];
    // Q side clocks stop while I is mirrored
    cfg.q_clk_en = ~spc[tdc_pkg::SPC_MIRROR_I];
  end

endmodule : tdc_path_dec
`default_nettype wire

// >>> tdc_cfg_regs.sv
`default_nettype none
// What this block does
// - Bit 7 bypasses premodulator, resets set
// - Bit 6 bypasses inverse sinc, resets set
// - Bit 5 bypasses oscillator; bit 3 halves gain
// - Bit 2 bypasses phase and dc correction
// - Bit 1 selects low-side inverted image
// - Bit 0 mirrors I onto Q, stops Q
// - First stage mode, upper bit modulates
// - First stage bypass bit, resets clear
// - Second stage doubled code, top modulates
// - Second stage mode resets to zero
// - Second stage bypass bit, resets clear
module tdc_cfg_regs (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [tdc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [tdc_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [tdc_pkg::DATA_W-1:0] reg_rdata,
  output logic reg_rd_miss,
  output tdc_pkg::tdc_path_cfg_s path_cfg,
  output tdc_pkg::tdc_hb_cfg_s hb1_cfg,
  output tdc_pkg::tdc_hb_cfg_s hb2_cfg
);

  typedef enum logic [1:0] {
    TDC_SEL_NONE = 2'b00,
    TDC_SEL_SPC = 2'b01,
    TDC_SEL_FHB = 2'b10,
    TDC_SEL_SHB = 2'b11
  } tdc_sel_e;

  typedef struct packed {
    logic [7:0] spc;
    logic [7:0] fhb;
    logic [7:0] shb;
    logic [tdc_pkg::DATA_W-1:0] rdata;
    logic rd_miss;
    tdc_pkg::tdc_path_cfg_s path;
    tdc_pkg::tdc_hb_cfg_s hb1;
    tdc_pkg::tdc_hb_cfg_s hb2;
  } tdc_state_s;

  tdc_state_s state_q;
  tdc_state_s state_d;
  tdc_pkg::tdc_bus_req_s req;
  tdc_sel_e sel;
  tdc_pkg::tdc_path_cfg_s path_dec;
  logic hb1_mod;
  logic [tdc_pkg::BAND_W-1:0] hb1_band;
  logic hb1_bad;
  logic hb2_mod;
  logic [tdc_pkg::BAND_W-1:0] hb2_band;
  logic hb2_bad;
  logic [tdc_pkg::FHB_MODE_W-1:0] hb1_mode;
  logic [tdc_pkg::SHB_MODE_W-1:0] hb2_mode;

  assign req.addr = reg_addr;
  assign req.wdata = reg_wdata;
  assign req.wr = reg_wr;
  assign req.rd = reg_rd;

  // Address decode
  always_comb begin
    case (req.addr)
      tdc_pkg::SPC_ADDR: begin
        sel = TDC_SEL_SPC;
      end
      tdc_pkg::FHB_ADDR: begin
        sel = TDC_SEL_FHB;
      end
      tdc_pkg::SHB_ADDR: begin
        sel = TDC_SEL_SHB;
      end
      default: begin
        sel = TDC_SEL_NONE;
      end
    endcase
  end

  assign hb1_mode = state_q.fhb[tdc_pkg::HB_MODE_LSB +: tdc_pkg::FHB_MODE_W];
  assign hb2_mode = state_q.shb[tdc_pkg::HB_MODE_LSB +: tdc_pkg::SHB_MODE_W];

  tdc_path_dec u_path_dec (
    .spc(state_q.spc),
    .cfg(path_dec)
  );

  tdc_hb_dec #(
    .CODE_W(tdc_pkg::FHB_CODE_W),
    .REPS(tdc_pkg::FHB_REPS),
    .BAND_W(tdc_pkg::BAND_W)
  ) u_hb1_dec (
    .mode(hb1_mode),
    .modulate(hb1_mod),
    .band(hb1_band),
    .mismatch(hb1_bad)
  );

  tdc_hb_dec #(
    .CODE_W(tdc_pkg::SHB_CODE_W),
    .REPS(tdc_pkg::SHB_REPS),
    .BAND_W(tdc_pkg::BAND_W)
  ) u_hb2_dec (
    .mode(hb2_mode),
    .modulate(hb2_mod),
    .band(hb2_band),
    .mismatch(hb2_bad)
  );

  always_comb begin
    state_d = state_q;

    // Register writes, masked to implemented bits
    if (req.wr) begin
      case (sel)
        TDC_SEL_SPC: begin
          state_d.spc = req.wdata & tdc_pkg::SPC_MASK;
        end
        TDC_SEL_FHB: begin
          state_d.fhb = req.wdata & tdc_pkg::FHB_MASK;
        end
        TDC_SEL_SHB: begin
          state_d.shb = req.wdata & tdc_pkg::SHB_MASK;
        end
        default: begin
          state_d.spc = state_q.spc;
        end
      endcase
    end

    // Read data stands for exactly one cycle after the strobe
    state_d.rdata = '0;
    state_d.rd_miss = 1'b0;
    if (req.rd) begin
      case (sel)
        TDC_SEL_SPC: begin
          state_d.rdata = state_q.spc & tdc_pkg::SPC_MASK;
        end
        TDC_SEL_FHB: begin
          state_d.rdata = state_q.fhb & tdc_pkg::FHB_MASK;
        end
        TDC_SEL_SHB: begin
          state_d.rdata = state_q.shb & tdc_pkg::SHB_MASK;
        end
        default: begin
          // Unmapped reads answer zero and flag it
          state_d.rd_miss = 1'b1;
        end
      endcase
    end

    // Decoded controls, registered so outputs come from flops
    state_d.path = path_dec;

    state_d.hb1.bypass = state_q.fhb[tdc_pkg::HB_BYP];
    state_d.hb1.modulate = hb1_mod;
    state_d.hb1.band = hb1_band;
    state_d.hb1.code_mismatch = hb1_bad;

    state_d.hb2.bypass = state_q.shb[tdc_pkg::HB_BYP];
    state_d.hb2.modulate = hb2_mod;
    state_d.hb2.band = hb2_band;
    // Non-doubled codes are kept but flagged; top copy wins
    state_d.hb2.code_mismatch = hb2_bad;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_q.spc <= tdc_pkg::SPC_RST;
      state_q.fhb <= tdc_pkg::FHB_RST;
      state_q.shb <= tdc_pkg::SHB_RST;
      state_q.rdata <= '0;
      state_q.rd_miss <= 1'b0;
      // Outputs match the reset register contents from the first cycle
      state_q.path.premod_bypass <= tdc_pkg::SPC_RST[tdc_pkg::SPC_PREMOD_BYP];
      state_q.path.isinc_bypass <= tdc_pkg::SPC_RST[tdc_pkg::SPC_ISINC_BYP];
      state_q.path.osc_bypass <= tdc_pkg::SPC_RST[tdc_pkg::SPC_OSC_BYP];
      state_q.path.osc_half_gain <= tdc_pkg::SPC_RST[tdc_pkg::SPC_OSC_HALF];
      state_q.path.phase_dc_bypass <= tdc_pkg::SPC_RST[tdc_pkg::SPC_PHDC_BYP];
      state_q.path.low_sideband <= tdc_pkg::SPC_RST[tdc_pkg::SPC_LOW_SIDE];
      state_q.path.mirror_inphase <= tdc_pkg::SPC_RST[tdc_pkg::SPC_MIRROR_I];
      state_q.path.q_clk_en <= ~tdc_pkg::SPC_RST[tdc_pkg::SPC_MIRROR_I];
      state_q.hb1 <= '0;
      state_q.hb2 <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign reg_rdata = state_q.rdata;
  assign reg_rd_miss = state_q.rd_miss;
  assign path_cfg = state_q.path;
  assign hb1_cfg = state_q.hb1;
  assign hb2_cfg = state_q.hb2;

endmodule : tdc_cfg_regs
`default_nettype wire

// >>> tdc_cfg_regs_props.sv
`default_nettype none
module tdc_cfg_props (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rd_miss,
  input wire tdc_pkg::tdc_path_cfg_s path_cfg,
  input wire tdc_pkg::tdc_hb_cfg_s hb1_cfg,
  input wire tdc_pkg::tdc_hb_cfg_s hb2_cfg
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  // Outputs lag a write by two edges: register, then decode
  sequence ws; reg_wr && reg_addr == tdc_pkg::SPC_ADDR; endsequence
  sequence w1; reg_wr && reg_addr == tdc_pkg::FHB_ADDR; endsequence
  sequence w2; reg_wr && reg_addr == tdc_pkg::SHB_ADDR; endsequence
  premod_byp_a: assert property (ws |=> ##1 path_cfg.premod_bypass == $past(reg_wdata[7], 2))
    else $error("premod bypass");
  isinc_byp_a: assert property (ws |=> ##1 path_cfg.isinc_bypass == $past(reg_wdata[6], 2))
    else $error("isinc bypass");
  osc_ctl_a: assert property (ws |=> ##1 {path_cfg.osc_bypass, path_cfg.osc_half_gain}
    == {$past(reg_wdata[5], 2), $past(reg_wdata[3], 2)}) else $error("osc control");
  phdc_byp_a: assert property (ws |=> ##1 path_cfg.phase_dc_bypass == $past(reg_wdata[2], 2))
    else $error("phase dc bypass");
  side_sel_a: assert property (ws |=> ##1 path_cfg.low_sideband == $past(reg_wdata[1], 2))
    else $error("sideband");
  mirror_q_a: assert property (ws |=> ##1 path_cfg.mirror_inphase == $past(reg_wdata[0], 2)
    && path_cfg.q_clk_en != path_cfg.mirror_inphase) else $error("mirror");
  hb_one_a: assert property (w1 |=> ##1 {hb1_cfg.bypass, hb1_cfg.modulate}
    == {$past(reg_wdata[0], 2), $past(reg_wdata[2], 2)}) else $error("first stage");
  hb_two_a: assert property (w2 |=> ##1 {hb2_cfg.bypass, hb2_cfg.modulate}
    == {$past(reg_wdata[0], 2), $past(reg_wdata[6], 2)}) else $error("second stage");
  reset_cfg_a: assert property ($fell(srst) |-> path_cfg == 8'he9 && hb2_cfg == 6'h00)
    else $error("reset config");
  read_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data idle");
  cover property (ws);
  cover property (w2);
  cover property (reg_rd_miss);
endmodule : tdc_cfg_props
bind tdc_cfg_regs tdc_cfg_props u_props (
  .ref_clk(ref_clk),
  .srst(srst),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .reg_rd_miss(reg_rd_miss),
  .path_cfg(path_cfg),
  .hb1_cfg(hb1_cfg),
  .hb2_cfg(hb2_cfg)
);
`default_nettype wire

// >>> tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic reg_rd_miss;
  tdc_pkg::tdc_path_cfg_s path_cfg;
  tdc_pkg::tdc_hb_cfg_s hb1_cfg;
  tdc_pkg::tdc_hb_cfg_s hb2_cfg;
  int err_total = 0;
  int total_checks = 0;
  int cycles = 0;
  always #4 ref_clk = ~ref_clk;
  tdc_cfg_regs uut (
    .ref_clk(ref_clk),
    .srst(srst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .reg_rd_miss(reg_rd_miss),
    .path_cfg(path_cfg),
    .hb1_cfg(hb1_cfg),
    .hb2_cfg(hb2_cfg)
  );
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Data is sampled 1 ns into the only cycle it stands
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask : rd
  task automatic t_reset;
    rd(tdc_pkg::SPC_ADDR, 8'he4);
    chk(path_cfg, 8'he9);
    rd(tdc_pkg::FHB_ADDR, 8'h00);
    rd(tdc_pkg::SHB_ADDR, 8'h00);
    chk({hb1_cfg, hb2_cfg[5:4]}, 8'h00);
    chk({2'b00, hb2_cfg}, 8'h00);
  endtask : t_reset
  task automatic t_spc;
    logic [7:0] w;
    for (int i = 0; i < 8; i++) begin
      w = 8'h01 << i;
      wr(tdc_pkg::SPC_ADDR, w);
      rd(tdc_pkg::SPC_ADDR, w & 8'hef);
      chk(path_cfg, {w[7:5], w[3:0], ~w[0]});
    end
  endtask : t_spc
  task automatic t_hb1;
    logic [7:0] w;
    for (int i = 0; i < 4; i++) begin
      w = {5'h1f, i[1:0], i[0]};
      wr(tdc_pkg::FHB_ADDR, w);
      rd(tdc_pkg::FHB_ADDR, w & 8'h07);
      chk({2'b00, hb1_cfg}, {2'b00, w[0], w[2], 1'b0, w[2:1], 1'b0});
    end
  endtask : t_hb1
  task automatic t_hb2;
    logic [7:0] w;
    for (int i = 0; i < 8; i++) begin
      w = {1'b1, i[2:0], i[2:0], i[0]};
      wr(tdc_pkg::SHB_ADDR, w);
      rd(tdc_pkg::SHB_ADDR, w & 8'h7f);
      chk({2'b00, hb2_cfg}, {2'b00, w[0], w[6], w[6:4], 1'b0});
    end
    // Halves disagree: upper half wins, flag raised
    wr(tdc_pkg::SHB_ADDR, 8'h54);
    rd(tdc_pkg::SHB_ADDR, 8'h54);
    chk({2'b00, hb2_cfg}, 8'h1b);
  endtask : t_hb2
  task automatic t_miss;
    wr(8'h1e, 8'hff);
    rd(8'h1e, 8'h00);
    chk({7'h00, reg_rd_miss}, 8'h01);
    rd(tdc_pkg::SPC_ADDR, 8'h80);
    chk({7'h00, reg_rd_miss}, 8'h00);
    // Second reset in mid-run restores defaults; driven on the edge
    @(posedge ref_clk);
    srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    rd(tdc_pkg::SPC_ADDR, 8'he4);
    chk(path_cfg, 8'he9);
    rd(tdc_pkg::FHB_ADDR, 8'h00);
    rd(tdc_pkg::SHB_ADDR, 8'h00);
    chk({hb1_cfg, 2'b00}, 8'h00);
    chk({2'b00, hb2_cfg}, 8'h00);
  endtask : t_miss
  task automatic summarize;
    if (err_total == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_total++;
      summarize();
    end
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    srst <= 1'b0;
    t_reset();
    t_spc();
    t_hb1();
    t_hb2();
    t_miss();
    summarize();
  end
endmodule : tb_top
`default_nettype wire
